// *** sync_serial_pkg.sv ***
// Constants and carrier types for the synchronous serial port registers.
// Assumes an APB master with 32-bit data and 8-bit byte addresses.
package sync_serial_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
  localparam logic [7:0] OFS_BUFFER = 8'h0C;
  localparam logic [7:0] OFS_ADDR_DIV = 8'h10;

  // Status field positions
  localparam int BIT_SMP = 7;
  localparam int BIT_CKE = 6;
  localparam int BIT_DA = 5;
  localparam int BIT_STOP = 4;
  localparam int BIT_START = 3;
  localparam int BIT_RW = 2;
  localparam int BIT_UA = 1;
  localparam int BIT_BF = 0;

  // Control one field positions
  localparam int BIT_WRITE_COLLISION_FLAG = 7;
  localparam int BIT_OV = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_CKP = 4;

  // Control two field positions
  localparam int BIT_GENERAL_CALL_ENABLE = 7;
  localparam int BIT_ACK_STATUS_BIT = 6;
  localparam int BIT_ACK_VALUE_BIT = 5;
  localparam int BIT_ACK_SEQUENCE_ENABLE = 4;
  localparam int BIT_RECEIVE_ENABLE_BIT = 3;
  localparam int BIT_PEN = 2;
  localparam int BIT_REPEATED_START_ENABLE = 1;
  localparam int BIT_SEN = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;

  // Half periods of the serial clock, in system clocks
  localparam logic [8:0] HALF_DIV4 = 9'h002;
  localparam logic [8:0] HALF_DIV16 = 9'h008;
  localparam logic [8:0] HALF_DIV64 = 9'h020;

  typedef enum logic [3:0] {
    M_SPI_DIV4 = 4'b0000,
    M_SPI_DIV16 = 4'b0001,
    M_SPI_DIV64 = 4'b0010,
    M_SPI_TMR2 = 4'b0011,
    M_SPI_SLV_SEL = 4'b0100,
    M_SPI_SLV = 4'b0101,
    M_I2C_SLV7 = 4'b0110,
    M_I2C_SLV10 = 4'b0111,
    M_I2C_MST = 4'b1000,
    M_RSVD9 = 4'b1001,
    M_SPI_MST_BRG = 4'b1010,
    M_I2C_FW_MST = 4'b1011,
    M_RSVDC = 4'b1100,
    M_RSVDD = 4'b1101,
    M_I2C_SLV7_SP = 4'b1110,
    M_I2C_SLV10_SP = 4'b1111
  } mode_t;

  // Events from the shift engine, each a one-cycle pulse unless noted
  typedef struct packed {
    logic busy;          // level: a word is on the wire
    logic start_det;
    logic stop_det;
    logic rx_done;
    logic [7:0] rx_byte;
    logic byte_is_data;  // qualifies rx_done and tx_done
    logic addr_match;
    logic rw_bit;        // qualifies addr_match
    logic nack;
    logic ack_rx;
    logic ack_bad;       // qualifies ack_rx
    logic gen_call;
    logic need_addr;
    logic tx_done;
    logic start_done;
    logic rstart_done;
    logic stop_done;
    logic rx_end;
    logic ack_done;
  } evt_t;

  // Controls to the shift engine and pin multiplexer
  typedef struct packed {
    logic port_on;
    logic [3:0] mode;
    logic is_i2c;
    logic is_master;
    logic sample_end;
    logic edge_sel;
    logic clk_pol;
    logic stretch_en;
    logic gen_call_en;
    logic ack_value;
    logic start_go;
    logic rstart_go;
    logic stop_go;
    logic rx_go;
    logic ack_go;
    logic tx_load;
    logic [7:0] tx_data;
    logic [7:0] divider;
    logic sck;
    logic gc_irq;
    logic rate_tick;
  } ctl_t;

endpackage

// *** ssp_rate_divider.sv ***
// Serial clock half-period timer for the master modes.
// Assumes run is low whenever no word is on the wire.
`timescale 1ns/10ps
module ssp_rate_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [3:0] mode,
  input wire logic [7:0] divider,
  input wire logic t2_match,
  output logic tick
);
  import sync_serial_pkg::*;

  // Ten bits: a divider of 255 needs a half period of 512
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } div_st_t;

  div_st_t s;
  div_st_t n;
  logic [9:0] half;

  // Zero divider is unsupported; it simply behaves as divide by four
  always_comb begin
    case (mode)
      M_SPI_DIV16: half = {1'b0, HALF_DIV16};
      M_SPI_DIV64: half = {1'b0, HALF_DIV64};
      M_SPI_MST_BRG, M_I2C_MST: half = {1'b0, divider, 1'b0} + 10'h002;
      default: half = {1'b0, HALF_DIV4};
    endcase
  end

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 10'h000;
    end else if (mode == M_SPI_TMR2) begin
      n.tick = t2_match;
    end else if (s.cnt + 10'h001 >= half) begin
      n.cnt = 10'h000;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule

// *** sync_serial_port_control.sv ***
// Status and control registers of the synchronous serial port.
// Assumes a shift engine that reports bus events on EVT and obeys CTL.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - Mode field picks I2C slave/master variants
// - Mode field picks SPI clock source
// - Mode 1010 divides by four times (divider + 1)
// - Sample bit picks input sample point
// - Edge bit picks SPI transmit edge
// - Data/address bit tracks last byte kind
// - Start/stop flags show last condition
// - Direction flag holds last read/write bit in I2C slave modes; in I2C master it shows a transmit in progress
// - Master idle when all command bits and the R/W flag clear
// - Ten-bit slave asks for address reload
// - Buffer full tracks buffer holding data
// - Write collision on badly timed buffer write
// - Slave overflow when buffer still full
// - Enable bit hands pins to port
// - Clock polarity or slave clock stretch
// - General call raises interrupt when enabled
// - Ack status and ack value bits
// - Ack sequence enable, hardware cleared
// - Start, restart, stop, receive commands
// - Slave start bit enables clock stretching
// - No command queueing while not idle
module sync_serial_port_control (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic T2_MATCH,
  input wire sync_serial_pkg::evt_t EVT,
  output sync_serial_pkg::ctl_t CTL
);
  import sync_serial_pkg::*;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] data_buffer;
    logic [7:0] address_divider_register;
    logic [7:0] tx_data;
    logic tx_load;
    logic gc_irq;
    logic sck;
    logic [7:0] rdata;
    logic err;
  } st_t;

  st_t s;
  st_t n;
  mode_t mode;
  logic is_i2c;
  logic is_master;
  logic is_slave;
  logic i2c_master;
  logic ten_bit;
  logic idle;
  logic access;
  logic setup;
  logic wr;
  logic coll;
  logic mapped;
  logic tick;
  logic [7:0] wbyte;

  assign mode = mode_t'(s.ctrl_one[3:0]);
  assign wbyte = PWDATA[7:0];

  // Mode decode
  always_comb begin
    is_i2c = 1'b0;
    is_master = 1'b0;
    case (mode)
      M_SPI_DIV4, M_SPI_DIV16, M_SPI_DIV64, M_SPI_TMR2: is_master = 1'b1;
      M_SPI_MST_BRG: is_master = 1'b1;
      M_I2C_MST, M_I2C_FW_MST: begin
        is_i2c = 1'b1;
        is_master = 1'b1;
      end
      M_I2C_SLV7, M_I2C_SLV10, M_I2C_SLV7_SP, M_I2C_SLV10_SP: begin
        is_i2c = 1'b1;
      end
      default: begin
        is_i2c = 1'b0;
        is_master = 1'b0;
      end
    endcase
  end

  // Reserved codes drive neither role
  assign is_slave = !is_master && mode != M_RSVD9 && mode != M_RSVDC &&
                    mode != M_RSVDD;
  assign i2c_master = is_i2c && is_master;
  assign ten_bit = mode == M_I2C_SLV10 || mode == M_I2C_SLV10_SP;

  assign idle = !(s.status[BIT_RW] | s.ctrl_two[BIT_ACK_SEQUENCE_ENABLE] |
                  s.ctrl_two[BIT_RECEIVE_ENABLE_BIT] | s.ctrl_two[BIT_PEN] |
                  s.ctrl_two[BIT_REPEATED_START_ENABLE] | s.ctrl_two[BIT_SEN]);

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE && !s.err;
  assign coll = i2c_master ? !idle : EVT.busy;

  always_comb begin
    mapped = 1'b1;
    if (PADDR == OFS_STATUS) begin
      mapped = 1'b1;
    end else if (PADDR == OFS_CTRL_ONE) begin
      mapped = 1'b1;
    end else if (PADDR == OFS_CTRL_TWO) begin
      mapped = 1'b1;
    end else if (PADDR == OFS_BUFFER) begin
      mapped = 1'b1;
    end else if (PADDR == OFS_ADDR_DIV) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    n = s;
    n.tx_load = 1'b0;
    n.gc_irq = 1'b0;
    // Read data is captured in setup so the access phase never waits
    if (setup) begin
      n.err = !mapped;
      n.rdata = RESET_BYTE;
      if (PADDR == OFS_STATUS) begin
        n.rdata = s.status;
      end else if (PADDR == OFS_CTRL_ONE) begin
        n.rdata = s.ctrl_one;
      end else if (PADDR == OFS_CTRL_TWO) begin
        n.rdata = s.ctrl_two;
      end else if (PADDR == OFS_BUFFER) begin
        n.rdata = s.data_buffer;
      end else if (PADDR == OFS_ADDR_DIV) begin
        n.rdata = s.address_divider_register;
      end
    end
    // Software side first, so hardware sets below win over clears
    if (wr && PADDR == OFS_STATUS) begin
      n.status[BIT_SMP] = wbyte[BIT_SMP];
      n.status[BIT_CKE] = wbyte[BIT_CKE];
    end else if (wr && PADDR == OFS_CTRL_ONE) begin
      n.ctrl_one[5:0] = wbyte[5:0];
      n.ctrl_one[BIT_WRITE_COLLISION_FLAG] = s.ctrl_one[BIT_WRITE_COLLISION_FLAG] & wbyte[BIT_WRITE_COLLISION_FLAG];
      n.ctrl_one[BIT_OV] = s.ctrl_one[BIT_OV] & wbyte[BIT_OV];
    end else if (wr && PADDR == OFS_CTRL_TWO) begin
      n.ctrl_two[BIT_GENERAL_CALL_ENABLE] = wbyte[BIT_GENERAL_CALL_ENABLE];
      n.ctrl_two[BIT_ACK_VALUE_BIT] = wbyte[BIT_ACK_VALUE_BIT];
      if (!i2c_master) begin
        n.ctrl_two[BIT_SEN] = wbyte[BIT_SEN];
      end else if (idle) begin
        // Commands only set; a busy port drops them
        n.ctrl_two[4:0] = s.ctrl_two[4:0] | wbyte[4:0];
      end
    end else if (wr && PADDR == OFS_BUFFER) begin
      if (coll) begin
        n.ctrl_one[BIT_WRITE_COLLISION_FLAG] = 1'b1;
      end else begin
        n.tx_data = wbyte;
        n.tx_load = 1'b1;
        if (is_i2c) begin
          n.status[BIT_BF] = 1'b1;
        end
        if (i2c_master) begin
          n.status[BIT_RW] = 1'b1;
        end
      end
    end else if (wr && PADDR == OFS_ADDR_DIV) begin
      n.address_divider_register = wbyte;
      n.status[BIT_UA] = 1'b0;
    end
    if (access && !PWRITE && PADDR == OFS_BUFFER) begin
      n.status[BIT_BF] = 1'b0;
    end
    if (!s.ctrl_one[BIT_EN]) begin
      n.status[BIT_STOP] = 1'b0;
      n.status[BIT_START] = 1'b0;
    end else begin
      if (EVT.start_det) begin
        n.status[BIT_START] = 1'b1;
        n.status[BIT_STOP] = 1'b0;
      end
      if (EVT.stop_det) begin
        n.status[BIT_STOP] = 1'b1;
        n.status[BIT_START] = 1'b0;
      end
      if (!is_master && (EVT.start_det || EVT.stop_det || EVT.nack)) begin
        n.status[BIT_RW] = 1'b0;
      end
      if (is_i2c && !is_master && EVT.addr_match) begin
        n.status[BIT_RW] = EVT.rw_bit;
        n.status[BIT_DA] = 1'b0;
      end
      if (EVT.rx_done) begin
        if (is_i2c) begin
          n.status[BIT_DA] = EVT.byte_is_data;
        end
        // In slave modes the shift contents are lost when the previous byte is unread
        if (is_slave && s.status[BIT_BF]) begin
          n.ctrl_one[BIT_OV] = 1'b1;
        end else begin
          n.data_buffer = EVT.rx_byte;
          n.status[BIT_BF] = 1'b1;
        end
      end
      if (EVT.tx_done) begin
        n.status[BIT_BF] = 1'b0;
        if (is_i2c) begin
          n.status[BIT_DA] = EVT.byte_is_data;
        end
        if (i2c_master) begin
          n.status[BIT_RW] = 1'b0;
        end
      end
      if (EVT.ack_rx) begin
        n.status[BIT_DA] = n.status[BIT_DA];
        n.ctrl_two[BIT_ACK_STATUS_BIT] = EVT.ack_bad;
      end
      if (is_i2c && !is_master && s.ctrl_two[BIT_GENERAL_CALL_ENABLE] && EVT.gen_call) begin
        n.gc_irq = 1'b1;
      end
      if (ten_bit && EVT.need_addr) begin
        n.status[BIT_UA] = 1'b1;
      end
      if (i2c_master) begin
        if (EVT.start_done) begin
          n.ctrl_two[BIT_SEN] = 1'b0;
        end
        if (EVT.rstart_done) begin
          n.ctrl_two[BIT_REPEATED_START_ENABLE] = 1'b0;
        end
        if (EVT.stop_done) begin
          n.ctrl_two[BIT_PEN] = 1'b0;
        end
        if (EVT.rx_end) begin
          n.ctrl_two[BIT_RECEIVE_ENABLE_BIT] = 1'b0;
        end
        if (EVT.ack_done) begin
          n.ctrl_two[BIT_ACK_SEQUENCE_ENABLE] = 1'b0;
        end
      end
    end
    // Idle level follows polarity; toggles only while a word shifts
    if (!EVT.busy || is_i2c) begin
      n.sck = s.ctrl_one[BIT_CKP];
    end else if (tick) begin
      n.sck = !s.sck;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s <= '0;
    end else if (CE) begin
      s <= n;
    end
  end

  ssp_rate_divider u_rate (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .run(s.ctrl_one[BIT_EN] && EVT.busy && is_master),
    .mode(s.ctrl_one[3:0]),
    .divider(s.address_divider_register),
    .t2_match(T2_MATCH),
    .tick(tick)
  );

  assign PRDATA = {24'h000000, s.rdata};
  assign PREADY = 1'b1;
  assign PSLVERR = access && s.err;

  always_comb begin
    CTL.port_on = s.ctrl_one[BIT_EN];
    CTL.mode = s.ctrl_one[3:0];
    CTL.is_i2c = is_i2c;
    CTL.is_master = is_master;
    CTL.sample_end = s.status[BIT_SMP];
    CTL.edge_sel = s.status[BIT_CKE];
    CTL.clk_pol = s.ctrl_one[BIT_CKP];
    CTL.stretch_en = !is_master && s.ctrl_two[BIT_SEN];
    CTL.gen_call_en = s.ctrl_two[BIT_GENERAL_CALL_ENABLE];
    CTL.ack_value = s.ctrl_two[BIT_ACK_VALUE_BIT];
    CTL.start_go = i2c_master && s.ctrl_two[BIT_SEN];
    CTL.rstart_go = i2c_master && s.ctrl_two[BIT_REPEATED_START_ENABLE];
    CTL.stop_go = i2c_master && s.ctrl_two[BIT_PEN];
    CTL.rx_go = i2c_master && s.ctrl_two[BIT_RECEIVE_ENABLE_BIT];
    CTL.ack_go = i2c_master && s.ctrl_two[BIT_ACK_SEQUENCE_ENABLE];
    CTL.tx_load = s.tx_load;
    CTL.tx_data = s.tx_data;
    CTL.divider = s.address_divider_register;
    CTL.sck = s.sck;
    CTL.gc_irq = s.gc_irq;
    CTL.rate_tick = tick;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_START_LAST: assert property (
    CE && s.ctrl_one[BIT_EN] && EVT.start_det && !EVT.stop_det |=>
      s.status[BIT_START] && !s.status[BIT_STOP])
    else $error("start flag not set or stop flag not cleared");

  AST_OFF_CLEARS: assert property (
    CE && !s.ctrl_one[BIT_EN] |=>
      !s.status[BIT_START] && !s.status[BIT_STOP])
    else $error("condition flags survive a disabled port");

  AST_NO_QUEUE: assert property (
    CE && i2c_master && !idle && !s.ctrl_two[BIT_RECEIVE_ENABLE_BIT] &&
    wr && PADDR == OFS_CTRL_TWO |=> !s.ctrl_two[BIT_RECEIVE_ENABLE_BIT])
    else $error("command accepted while port busy");

  AST_WRITE_COLLISION_FLAG_SET: assert property (
    CE && wr && PADDR == OFS_BUFFER && coll |=>
      s.ctrl_one[BIT_WRITE_COLLISION_FLAG] && !s.tx_load)
    else $error("collision not flagged or write not ignored");

  AST_OV_SLAVE: assert property (
    CE && s.ctrl_one[BIT_EN] && is_slave && EVT.rx_done &&
    s.status[BIT_BF] |=> s.ctrl_one[BIT_OV] && $stable(s.data_buffer))
    else $error("overflow missed or buffer overwritten");

  AST_OV_MASTER: assert property (
    CE && is_master && !s.ctrl_one[BIT_OV] |=> !s.ctrl_one[BIT_OV])
    else $error("overflow set in master mode");

  AST_BF_RX: assert property (
    CE && s.ctrl_one[BIT_EN] && EVT.rx_done && !s.status[BIT_BF] |=>
      s.status[BIT_BF] && s.data_buffer == $past(EVT.rx_byte))
    else $error("received byte not latched");

  AST_ACK_DONE: assert property (
    CE && i2c_master && s.ctrl_one[BIT_EN] && EVT.ack_done &&
    !(wr && PADDR == OFS_CTRL_TWO) |=> !s.ctrl_two[BIT_ACK_SEQUENCE_ENABLE])
    else $error("ack enable not cleared by hardware");

  AST_RW_SLAVE: assert property (
    CE && s.ctrl_one[BIT_EN] && is_i2c && !is_master &&
    EVT.addr_match |=> s.status[BIT_RW] == $past(EVT.rw_bit))
    else $error("direction flag does not follow address");

  AST_GC_IRQ: assert property (
    CE && s.ctrl_one[BIT_EN] && is_i2c && !is_master &&
    s.ctrl_two[BIT_GENERAL_CALL_ENABLE] && EVT.gen_call |=> CTL.gc_irq)
    else $error("general call interrupt missing");
endmodule

// *** ssp_engine_model.sv ***
// Behavioural shift engine standing on the far side of the port block.
// Assumes the bench injects bus events on inj; lat sets its speed.
`timescale 1ns/10ps
module ssp_engine_model
  import sync_serial_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire sync_serial_pkg::evt_t inj,
  input wire sync_serial_pkg::ctl_t ctl,
  output sync_serial_pkg::evt_t evt
);
  logic [3:0] cnt;
  logic txing;
  evt_t fin;
  wire logic go = ctl.start_go | ctl.rstart_go | ctl.stop_go | ctl.rx_go |
    ctl.ack_go;
  always_ff @(posedge clk) begin
    fin <= '0;
    if (!rst_n) begin
      cnt <= 4'h0;
      txing <= 1'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        fin.start_done <= ctl.start_go;
        fin.rstart_done <= ctl.rstart_go;
        fin.stop_done <= ctl.stop_go;
        fin.rx_end <= ctl.rx_go;
        fin.ack_done <= ctl.ack_go;
        fin.tx_done <= txing;
        fin.byte_is_data <= txing;
        txing <= 1'h0;
      end
    // Skip the finish edge: the command bit still stands until it clears
    end else if ((ctl.tx_load | go) && fin == '0) begin
      // One operation at a time, never queued
      cnt <= lat;
      txing <= ctl.tx_load;
    end
  end
  always_comb begin
    evt = inj | fin;
    evt.busy = inj.busy | txing;
  end
endmodule

// *** sync_serial_port_control_tb.sv ***
// Self-checking bench for the serial port register block.
// Assumes the engine model on EVT/CTL; CE tied high throughout.
`timescale 1ns/10ps
module sync_serial_port_control_tb;
  import sync_serial_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, t2, rerr;
  logic [7:0] paddr, r, c;
  logic [31:0] pwdata, rdat;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  logic [3:0] lat;
  evt_t inj, e;
  wire evt_t evt;
  wire ctl_t ctl;
  ctl_t snap;
  int n_fail, checks, j, m;

  sync_serial_port_control u_dut (.CLK(clk), .RST_N(rst_n), .CE(1'h1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .T2_MATCH(t2), .EVT(evt), .CTL(ctl));
  ssp_engine_model u_eng (.clk(clk), .rst_n(rst_n), .lat(lat), .inj(inj),
    .ctl(ctl), .evt(evt));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'h0, a, 8'h00);
    chk8(rdat[7:0], x);
  endtask

  task automatic ev(input evt_t v);
    inj <= v;
    @(posedge clk);
    inj <= '0;
    #1 snap = ctl;
    @(posedge clk);
  endtask

  function automatic logic [7:0] c2_exp(input logic [7:0] d);
    return d & 8'hA1;
  endfunction

  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) t2 <= 1'($urandom);

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out;
  end

  initial begin
    {psel, penable, pwrite, t2, rst_n} = '0;
    paddr = 8'h00;
    pwdata = '0;
    inj = '0;
    lat = 4'h2;
    n_fail = 0;
    checks = 0;
    void'($urandom(32'h229B2611));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(OFS_STATUS, RESET_BYTE);
    rd(OFS_CTRL_ONE, RESET_BYTE);
    rd(OFS_CTRL_TWO, RESET_BYTE);
    rd(OFS_ADDR_DIV, RESET_BYTE);
    apb(1'h0, 8'h14, 8'h00);
    chk8({7'h0, rerr}, 8'h01);
    chk8(rdat[7:0], 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      r = 8'($urandom) & 8'hDF;
      apb(1'h1, OFS_CTRL_ONE, r);
      rd(OFS_CTRL_ONE, r & 8'h3F);
      chk8({4'h0, ctl.mode}, {4'h0, r[3:0]});
      chk8({7'h0, ctl.clk_pol}, {7'h0, r[BIT_CKP]});
      c = 8'($urandom);
      apb(1'h1, OFS_STATUS, c);
      rd(OFS_STATUS, c & 8'hC0);
      chk8({6'h0, ctl.sample_end, ctl.edge_sel}, {6'h0, c[7:6]});
      if (r[3:0] == 4'h8 && c < 8'h03) begin
        c = 8'h03;
      end
      apb(1'h1, OFS_ADDR_DIV, c);
      rd(OFS_ADDR_DIV, c);
      if (r[3:0] != 4'h8 && r[3:0] != 4'hB) begin
        apb(1'h1, OFS_CTRL_TWO, ~c);
        rd(OFS_CTRL_TWO, c2_exp(~c));
      end
    end
    // Leave I2C master mode first so control two bits can be cleared
    apb(1'h1, OFS_CTRL_ONE, 8'h00);
    apb(1'h1, OFS_CTRL_TWO, 8'h00);
    apb(1'h1, OFS_STATUS, 8'h00);
    $display("test random regs done");
    apb(1'h1, OFS_CTRL_ONE, 8'h26);
    chk8({7'h0, ctl.port_on}, 8'h01);
    e = '0;
    e.start_det = 1'h1;
    ev(e);
    rd(OFS_STATUS, 8'h08);
    e = '0;
    e.addr_match = 1'h1;
    e.rw_bit = 1'h1;
    ev(e);
    rd(OFS_STATUS, 8'h0C);
    r = 8'($urandom);
    e = '0;
    e.rx_done = 1'h1;
    e.byte_is_data = 1'h1;
    e.rx_byte = r;
    ev(e);
    rd(OFS_STATUS, 8'h2D);
    e.rx_byte = ~r;
    ev(e);
    rd(OFS_CTRL_ONE, 8'h66);
    rd(OFS_BUFFER, r);
    rd(OFS_STATUS, 8'h2C);
    e = '0;
    e.stop_det = 1'h1;
    ev(e);
    rd(OFS_STATUS, 8'h30);
    lat <= 4'h8;
    apb(1'h1, OFS_CTRL_ONE, 8'h26);
    apb(1'h1, OFS_BUFFER, r);
    apb(1'h1, OFS_BUFFER, ~r);
    rd(OFS_CTRL_ONE, 8'hA6);
    // Let the word finish so its done event is not lost to the disable
    repeat (8) @(posedge clk);
    apb(1'h1, OFS_CTRL_ONE, 8'h06);
    rd(OFS_STATUS, 8'h20);
    chk8({7'h0, ctl.port_on}, 8'h00);
    $display("test slave done");
    apb(1'h1, OFS_CTRL_ONE, 8'h26);
    for (int g = 0; g < 2; g++) begin
      apb(1'h1, OFS_CTRL_TWO, {g[0], 7'h00});
      e = '0;
      e.gen_call = 1'h1;
      ev(e);
      chk8({7'h0, snap.gc_irq}, {7'h0, g[0]});
    end
    apb(1'h1, OFS_CTRL_TWO, 8'h00);
    apb(1'h1, OFS_CTRL_ONE, 8'h27);
    e = '0;
    e.need_addr = 1'h1;
    ev(e);
    apb(1'h0, OFS_STATUS, 8'h00);
    chk8({7'h0, rdat[BIT_UA]}, 8'h01);
    apb(1'h1, OFS_ADDR_DIV, r);
    apb(1'h0, OFS_STATUS, 8'h00);
    chk8({7'h0, rdat[BIT_UA]}, 8'h00);
    $display("test slave events done");
    lat <= 4'hF;
    apb(1'h1, OFS_CTRL_ONE, 8'h28);
    apb(1'h1, OFS_ADDR_DIV, 8'h03);
    for (int i = 0; i < 5; i++) begin
      c = 8'h01 << i;
      apb(1'h1, OFS_CTRL_TWO, c);
      rd(OFS_CTRL_TWO, c);
      apb(1'h1, OFS_CTRL_TWO, 8'h1F);
      rd(OFS_CTRL_TWO, c);
      if (i == 0) begin
        apb(1'h1, OFS_BUFFER, r);
        rd(OFS_CTRL_ONE, 8'hA8);
        apb(1'h1, OFS_CTRL_ONE, 8'h28);
      end
      j = 0;
      do begin
        apb(1'h0, OFS_CTRL_TWO, 8'h00);
        j++;
      end while (rdat[4:0] !== 5'h00 && j < 20);
      chk8(rdat[7:0], 8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      e = '0;
      e.ack_rx = 1'h1;
      e.ack_bad = b[0];
      ev(e);
      rd(OFS_CTRL_TWO, {1'h0, b[0], 6'h00});
    end
    e = '0;
    e.rx_done = 1'h1;
    e.rx_byte = r;
    ev(e);
    ev(e);
    rd(OFS_CTRL_ONE, 8'h28);
    apb(1'h0, OFS_BUFFER, 8'h00);
    apb(1'h1, OFS_BUFFER, r);
    apb(1'h0, OFS_STATUS, 8'h00);
    chk8({6'h0, rdat[BIT_RW], rdat[BIT_BF]}, 8'h03);
    rd(OFS_CTRL_ONE, 8'h28);
    apb(1'h1, OFS_CTRL_TWO, 8'h01);
    rd(OFS_CTRL_TWO, 8'h40);
    repeat (16) @(posedge clk);
    rd(OFS_STATUS, 8'h20);
    apb(1'h1, OFS_CTRL_TWO, 8'h01);
    rd(OFS_CTRL_TWO, 8'h41);
    $display("test master done");
    repeat (16) @(posedge clk);
    apb(1'h1, OFS_CTRL_ONE, 8'h2A);
    apb(1'h1, OFS_ADDR_DIV, 8'h01);
    apb(1'h1, OFS_BUFFER, r);
    j = 0;
    m = 0;
    do begin
      @(negedge clk);
      j++;
    end while (ctl.rate_tick !== 1'h1 && j < 20);
    do begin
      @(negedge clk);
      m++;
    end while (ctl.rate_tick !== 1'h1 && m < 20);
    chk8(8'(m), 8'h04);
    $display("test spi rate done");
    close_out;
  end
endmodule
